//--- hw/srfu_top.v
// shift, rotate and flag unit with axi4-lite register access
// assumes a single aclk domain; sleep, watchdog and debug units sit outside
`timescale 1ns/1ps
`include "srfu_regs.vh"
module srfu_top (
   input wire aclk,
   input wire aresetn,
   input wire [`SRFU_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`SRFU_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire debug_enable,
   output reg sleep_request,
   output reg watchdog_restart,
   output reg debug_break
);
   localparam [1:0] RESP_OKAY = 2'b00;
   localparam [1:0] RESP_SLVERR = 2'b10;

   ////////////////////////////////////////////////////////////////////////////
   // state
   reg [7:0] wreg;
   reg [7:0] status_flags_register;
   reg [7:0] wd_count;
   reg dbg_meta;
   reg dbg_sync;
   reg [`SRFU_ADDR_W-1:0] aw_addr;
   reg aw_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_held;

   wire [7:0] exec_wreg;
   wire [7:0] exec_flags;
   wire wr_go;
   wire cmd_go;
   wire [4:0] cmd_op;
   wire [2:0] cmd_bit;

   ////////////////////////////////////////////////////////////////////////////
   // write channel capture, either order
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign cmd_go = wr_go && (aw_addr == `SRFU_OFF_CMD) && w_strb[0];
   assign cmd_op = w_data[`SRFU_CMD_OP_HI:0];
   assign cmd_bit = w_data[`SRFU_CMD_BIT_HI:`SRFU_CMD_BIT_LO];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {`SRFU_ADDR_W{1'b0}};
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr == `SRFU_OFF_STAT) begin
            s_axi_bresp <= RESP_SLVERR;
         end else begin
            s_axi_bresp <= RESP_OKAY;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // datapath
   srfu_exec u_exec (
      .op(cmd_op),
      .bsel(cmd_bit),
      .wreg_in(wreg),
      .flags_in(status_flags_register),
      .wreg_out(exec_wreg),
      .flags_out(exec_flags)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         dbg_meta <= 1'b0;
         dbg_sync <= 1'b0;
      end else begin
         dbg_meta <= debug_enable;
         dbg_sync <= dbg_meta;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         wreg <= `SRFU_WREG_RST;
         status_flags_register <= `SRFU_FLAGS_RST;
      end else if (cmd_go) begin
         wreg <= exec_wreg; // one clock per operation
         status_flags_register <= exec_flags;
      end else if (wr_go && aw_addr == `SRFU_OFF_WREG && w_strb[0]) begin
         wreg <= w_data[7:0];
      end else if (wr_go && aw_addr == `SRFU_OFF_FLAGS && w_strb[0]) begin
         status_flags_register <= w_data[7:0];
      end
   end

   // control instructions
   always @(posedge aclk) begin
      if (!aresetn) begin
         sleep_request <= 1'b0;
         watchdog_restart <= 1'b0;
         debug_break <= 1'b0;
         wd_count <= 8'h00;
      end else begin
         watchdog_restart <= cmd_go && cmd_op == `SRFU_OP_WDOG;
         if (cmd_go && cmd_op == `SRFU_OP_WDOG) begin
            wd_count <= wd_count + 8'h01;
         end
         if (cmd_go && cmd_op == `SRFU_OP_SLEEP) begin
            sleep_request <= 1'b1;
         end else if (cmd_go) begin
            sleep_request <= 1'b0;
         end
         if (cmd_go && cmd_op == `SRFU_OP_BREAK && dbg_sync) begin
            debug_break <= 1'b1;
         end else if (!dbg_sync || (cmd_go && cmd_op != `SRFU_OP_BREAK)) begin
            debug_break <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
               `SRFU_OFF_WREG: s_axi_rdata <= {24'h00_0000, wreg};
               `SRFU_OFF_FLAGS: s_axi_rdata <= {24'h00_0000, status_flags_register};
               `SRFU_OFF_CMD: s_axi_rdata <= 32'h0000_0000;
               `SRFU_OFF_STAT: s_axi_rdata <= {16'h0000, wd_count, 6'h00,
                                               debug_break, sleep_request};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

//--- hw/srfu_regs.vh
// constants for the shift, rotate and flag unit: register map, fields, opcodes
// assumes a 32-bit axi4-lite master and a 200 MHz aclk
`ifndef SRFU_REGS_VH
`define SRFU_REGS_VH

`define SRFU_ADDR_W 4
`define SRFU_OFF_WREG 4'h0
`define SRFU_OFF_FLAGS 4'h4
`define SRFU_OFF_CMD 4'h8
`define SRFU_OFF_STAT 4'hC

`define SRFU_WREG_RST 8'h00
`define SRFU_FLAGS_RST 8'h00

// status flag positions: c z n v s h t i
`define SRFU_F_C 0
`define SRFU_F_Z 1
`define SRFU_F_N 2
`define SRFU_F_V 3
`define SRFU_F_S 4
`define SRFU_F_H 5
`define SRFU_F_T 6
`define SRFU_F_I 7

// command word: opcode in [4:0], bit select in [10:8]
`define SRFU_CMD_OP_HI 4
`define SRFU_CMD_BIT_LO 8
`define SRFU_CMD_BIT_HI 10

`define SRFU_OP_NOP 5'h00
`define SRFU_OP_SHR_LOGIC 5'h01
`define SRFU_OP_ROLC 5'h02
`define SRFU_OP_RORC 5'h03
`define SRFU_OP_SHR_ARITH 5'h04
`define SRFU_OP_SWAP 5'h05
`define SRFU_OP_BSET 5'h06
`define SRFU_OP_BCLR 5'h07
`define SRFU_OP_BTOT 5'h08
`define SRFU_OP_TTOB 5'h09
`define SRFU_OP_SLEEP 5'h0A
`define SRFU_OP_WDOG 5'h0B
`define SRFU_OP_BREAK 5'h0C
`define SRFU_OP_SETV 5'h0D
`define SRFU_OP_CLRV 5'h0E
`define SRFU_OP_SETH 5'h0F
`define SRFU_OP_CLRH 5'h10
`define SRFU_OP_SETS 5'h11
`define SRFU_OP_CLRS 5'h12

// status register bits
`define SRFU_ST_SLEEP 0
`define SRFU_ST_BRK 1
`define SRFU_ST_WDCNT_LO 8

`endif

//--- hw/srfu_exec.v
// combinational shift, rotate and flag datapath
// assumes operands are stable in the cycle the command is applied
`timescale 1ns/1ps
`include "srfu_regs.vh"
module srfu_exec (
   input wire [4:0] op,
   input wire [2:0] bsel,
   input wire [7:0] wreg_in,
   input wire [7:0] flags_in,
   output reg [7:0] wreg_out,
   output reg [7:0] flags_out
);
   reg [7:0] res;
   reg cout;
   reg shift_op;
   always @* begin
      res = wreg_in;
      cout = flags_in[`SRFU_F_C];
      shift_op = 1'b0;
      wreg_out = wreg_in;
      flags_out = flags_in;
      case (op)
         `SRFU_OP_SHR_LOGIC: begin
            res = {1'b0, wreg_in[7:1]};
            cout = wreg_in[0];
            shift_op = 1'b1;
         end
         `SRFU_OP_ROLC: begin
            res = {wreg_in[6:0], flags_in[`SRFU_F_C]};
            cout = wreg_in[7];
            shift_op = 1'b1;
         end
         `SRFU_OP_RORC: begin
            res = {flags_in[`SRFU_F_C], wreg_in[7:1]};
            cout = wreg_in[0];
            shift_op = 1'b1;
         end
         `SRFU_OP_SHR_ARITH: begin
            res = {wreg_in[7], wreg_in[7:1]};
            cout = wreg_in[0];
            shift_op = 1'b1;
         end
         `SRFU_OP_SWAP: wreg_out = {wreg_in[3:0], wreg_in[7:4]};
         `SRFU_OP_BSET: flags_out[bsel] = 1'b1;
         `SRFU_OP_BCLR: flags_out[bsel] = 1'b0;
         `SRFU_OP_BTOT: flags_out[`SRFU_F_T] = wreg_in[bsel];
         `SRFU_OP_TTOB: wreg_out[bsel] = flags_in[`SRFU_F_T];
         `SRFU_OP_SETV: flags_out[`SRFU_F_V] = 1'b1;
         `SRFU_OP_CLRV: flags_out[`SRFU_F_V] = 1'b0;
         `SRFU_OP_SETH: flags_out[`SRFU_F_H] = 1'b1;
         `SRFU_OP_CLRH: flags_out[`SRFU_F_H] = 1'b0;
         `SRFU_OP_SETS: flags_out[`SRFU_F_S] = 1'b1;
         `SRFU_OP_CLRS: flags_out[`SRFU_F_S] = 1'b0;
         default: wreg_out = wreg_in; // sleep, watchdog, break, nop
      endcase
      if (shift_op) begin
         wreg_out = res;
         flags_out[`SRFU_F_C] = cout;
         flags_out[`SRFU_F_Z] = (res == 8'h00);
         flags_out[`SRFU_F_N] = res[7];
         flags_out[`SRFU_F_V] = res[7] ^ cout;
         flags_out[`SRFU_F_S] = res[7] ^ (res[7] ^ cout);
      end
   end
endmodule

//--- sim/srfu_properties.sv
// port checker for the shift, rotate and flag unit
// assumes binding to srfu_top with one aclk domain
`timescale 1ns/1ps
module srfu_properties (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire debug_enable,
   input wire sleep_request,
   input wire watchdog_restart,
   input wire debug_break
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence resp_near;
      s_axi_bvalid || $past(s_axi_bvalid);
   endsequence
   wr_resp_a: assert property (wr_both |=> ##1 s_axi_bvalid)
      else $error("write response late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   rd_err_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
      else $error("error read carries data");
   wd_pulse_a: assert property (watchdog_restart |=> !watchdog_restart)
      else $error("restart pulse too long");
   wd_cause_a: assert property ($rose(watchdog_restart) |-> resp_near)
      else $error("restart without command");
   sleep_cause_a: assert property ($rose(sleep_request) |-> resp_near)
      else $error("sleep without command");
   brk_gate_a: assert property (!debug_enable [*4] |=> !debug_break)
      else $error("break while debug off");
   rst_idle_a: assert property (disable iff (1'b0) !aresetn |=> !sleep_request && !debug_break
      && !watchdog_restart && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs busy after reset");
endmodule
bind srfu_top srfu_properties u_srfu_properties (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .debug_enable(debug_enable), .sleep_request(sleep_request),
   .watchdog_restart(watchdog_restart), .debug_break(debug_break));

//--- sim/tb.sv
// self-checking bench for srfu_top: random operands through every opcode
// assumes srfu_regs.vh on the include path
`timescale 1ns/1ps
`include "srfu_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
   reg aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, dbg = 0;
   reg [3:0] awaddr = 0, araddr = 0, wstrb = 4'hF;
   reg [31:0] wdata = 0, rd, seed = 32'h0001_7E20;
   wire awready, wready, bvalid, arready, rvalid, sleep_request, watchdog_restart, debug_break;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   reg [1:0] rsp;
   reg [15:0] ex;
   reg [7:0] opw, opf, wd_n = 0, pulses = 0;
   integer fail_count = 0, tests_run = 0, cycles = 0, i, op;
   srfu_top u_srfu_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .debug_enable(dbg), .sleep_request(sleep_request),
      .watchdog_restart(watchdog_restart), .debug_break(debug_break));
   initial forever #2.5 aclk = ~aclk;
   //////////////////////////////////////////////////////////////////////////////
   function [31:0] xs(input [31:0] s);
      begin
         s = s ^ (s << 13);
         s = s ^ (s >> 17);
         xs = s ^ (s << 5);
      end
   endfunction
   function [15:0] model(input [4:0] o, input [2:0] b, input [7:0] w, input [7:0] f);
      reg [7:0] r;
      reg c;
      begin
         r = w;
         c = w[0];
         case (o)
            `SRFU_OP_SHR_LOGIC: r = {1'b0, w[7:1]};
            `SRFU_OP_ROLC: begin r = {w[6:0], f[0]}; c = w[7]; end
            `SRFU_OP_RORC: r = {f[0], w[7:1]};
            `SRFU_OP_SHR_ARITH: r = {w[7], w[7:1]};
            `SRFU_OP_SWAP: r = {w[3:0], w[7:4]};
            `SRFU_OP_BSET: f[b] = 1'b1;
            `SRFU_OP_BCLR: f[b] = 1'b0;
            `SRFU_OP_BTOT: f[6] = w[b];
            `SRFU_OP_TTOB: r[b] = f[6];
            `SRFU_OP_SETV: f[3] = 1'b1;
            `SRFU_OP_CLRV: f[3] = 1'b0;
            `SRFU_OP_SETH: f[5] = 1'b1;
            `SRFU_OP_CLRH: f[5] = 1'b0;
            `SRFU_OP_SETS: f[4] = 1'b1;
            `SRFU_OP_CLRS: f[4] = 1'b0;
            default: r = w;
         endcase
         // s = n ^ v reduces to carry on shifts
         if (o >= 5'h01 && o <= 5'h04) f[4:0] = {c, r[7] ^ c, r[7], r == 8'h00, c};
         model = {r, f};
      end
   endfunction
   //////////////////////////////////////////////////////////////////////////////
   task wr(input [3:0] a, input [31:0] d);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awv <= 1;
         wv <= 1;
         bready <= 1;
         do begin
            @(posedge aclk);
            if (awv && awready) awv <= 0;
            if (wv && wready) wv <= 0;
         end while (!bvalid);
         bready <= 0;
         rsp = bresp;
      end
   endtask
   task rdt(input [3:0] a);
      begin
         @(posedge aclk);
         araddr <= a;
         arv <= 1;
         rready <= 1;
         do begin
            @(posedge aclk);
            if (arv && arready) arv <= 0;
         end while (!rvalid);
         rready <= 0;
         rd = rdata;
         rsp = rresp;
      end
   endtask
   task stop_test;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (watchdog_restart === 1'b1) pulses++;
      if (cycles == 8000) begin
         fail_count++;
         stop_test;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      rdt(`SRFU_OFF_FLAGS);
      `CHK(rd, 32'h0000_0000)
      for (i = 0; i < 76; i++) begin
         op = i % 19;
         seed = xs(seed);
         // second pass: single set bit at either end, zero results
         opw = (i >= 19 && i < 38) ? {i[0], 6'h00, ~i[0]} : seed[7:0];
         opf = seed[15:8];
         wr(`SRFU_OFF_WREG, {24'h0, opw});
         wr(`SRFU_OFF_FLAGS, {24'h0, opf});
         wr(`SRFU_OFF_CMD, {21'h0, seed[18:16], 3'h0, op[4:0]});
         ex = model(op[4:0], seed[18:16], opw, opf);
         if (op == `SRFU_OP_WDOG) wd_n++;
         if (op == `SRFU_OP_SLEEP) `CHK(sleep_request, 1'b1)
         if (op == `SRFU_OP_BREAK) `CHK(debug_break, 1'b0)
         rdt(`SRFU_OFF_WREG);
         `CHK(rd[7:0], ex[15:8])
         rdt(`SRFU_OFF_FLAGS);
         `CHK(rd[7:0], ex[7:0])
      end
      rdt(`SRFU_OFF_STAT);
      `CHK(rd[15:8], wd_n)
      `CHK(pulses, wd_n)
      dbg <= 1;
      repeat (4) @(posedge aclk);
      wr(`SRFU_OFF_CMD, {27'h0, `SRFU_OP_BREAK});
      `CHK(debug_break, 1'b1)
      dbg <= 0;
      repeat (6) @(posedge aclk);
      `CHK(debug_break, 1'b0)
      rdt(4'h2);
      `CHK(rsp, 2'b10)
      wr(`SRFU_OFF_STAT, 32'h0000_0000);
      `CHK(rsp, 2'b10)
      rdt(`SRFU_OFF_CMD);
      `CHK(rd, 32'h0000_0000)
      stop_test;
   end
endmodule
